//--- rtl/result_trigger_regs.v
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "result_trigger_consts.vh"

// How it works
// RULE1 - Each channel's high result byte holds the first eight result bits, MSB aligned.
// RULE2 - Each channel's low result byte holds the next eight result bits.
// RULE3 - All result bytes are read-only and reset to zero.
// RULE4 - Low bytes sit at even addresses with the high byte just above, 0xA7 to 0xAF.
// RULE5 - Each output has an eight-bit mask, bit n for channel n, any channel mode.
// RULE6 - A set mask bit lets that channel's alert update the output.
// RULE7 - A clear mask bit makes that channel's alert have no effect.
// RULE8 - Masks are read/write and reset to 0x02.
// RULE9 - The masks of outputs 0, 1 and 2 sit at 0xC3, 0xC5 and 0xC7.
// RULE10 - Both bytes of a channel are loaded together from one conversion.
module result_trigger_regs (
    input  wire        MCLK,
    input  wire        RESET,
    input  wire [7:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    input  wire [7:0]  CONV_DONE,
    input  wire [15:0] CONV_RESULT,
    input  wire [7:0]  ALERT,
    input  wire [2:0]  OUT_VALUE,
    output reg  [2:0]  DIGITAL_OUTPUT
);
    // Conversion-done strobes of the channels this bank keeps.
    wire        ch3_load;
    wire        ch4_load;
    wire        ch5_load;
    wire        ch6_load;
    wire        ch7_load;

    // Result bytes of channels 3 to 7 as the pair registers hold them.
    wire [7:0]  ch3_result_high_byte;
    wire [7:0]  ch4_result_low_byte;
    wire [7:0]  ch4_result_high_byte;
    wire [7:0]  ch5_result_low_byte;
    wire [7:0]  ch5_result_high_byte;
    wire [7:0]  ch6_result_low_byte;
    wire [7:0]  ch6_result_high_byte;
    wire [7:0]  ch7_result_low_byte;
    wire [7:0]  ch7_result_high_byte;

    // Trigger masks and trigger requests of the three digital outputs.
    wire [7:0]  output0_alert_trigger_mask;
    wire [7:0]  output1_alert_trigger_mask;
    wire [7:0]  output2_alert_trigger_mask;
    wire        trigger0;
    wire        trigger1;
    wire        trigger2;

    // One select line per mapped register, and their union.
    wire        sel_ch3_high;
    wire        sel_ch4_low;
    wire        sel_ch4_high;
    wire        sel_ch5_low;
    wire        sel_ch5_high;
    wire        sel_ch6_low;
    wire        sel_ch6_high;
    wire        sel_ch7_low;
    wire        sel_ch7_high;
    wire        sel_out0_mask;
    wire        sel_out1_mask;
    wire        sel_out2_mask;
    wire        sel_mapped;

    // Write enables exist only for the masks.
    wire        out0_mask_we;
    wire        out1_mask_we;
    wire        out2_mask_we;

    // Each register's byte, gated by its own select.
    wire [7:0]  read_ch3_high;
    wire [7:0]  read_ch4_low;
    wire [7:0]  read_ch4_high;
    wire [7:0]  read_ch5_low;
    wire [7:0]  read_ch5_high;
    wire [7:0]  read_ch6_low;
    wire [7:0]  read_ch6_high;
    wire [7:0]  read_ch7_low;
    wire [7:0]  read_ch7_high;
    wire [7:0]  read_out0_mask;
    wire [7:0]  read_out1_mask;
    wire [7:0]  read_out2_mask;
    wire [7:0]  read_mux;

    reg  [7:0]  rdata_d;
    reg  [2:0]  digital_output_d;

    // Bits 0 to 2 belong to channels whose results are kept outside this bank.
    assign ch3_load = CONV_DONE[3]; // RULE10
    assign ch4_load = CONV_DONE[4]; // RULE10
    assign ch5_load = CONV_DONE[5]; // RULE10
    assign ch6_load = CONV_DONE[6]; // RULE10
    assign ch7_load = CONV_DONE[7]; // RULE10

    // Channel 3's low byte lives outside this bank, so that output is left open.
    result_pair_reg u_ch3_pair (
        .clk       (MCLK),
        .rst       (RESET),
        .load      (ch3_load),
        .result    (CONV_RESULT),
        .high_byte (ch3_result_high_byte),
        .low_byte  ()
    );

    result_pair_reg u_ch4_pair (
        .clk       (MCLK),
        .rst       (RESET),
        .load      (ch4_load),
        .result    (CONV_RESULT),
        .high_byte (ch4_result_high_byte),
        .low_byte  (ch4_result_low_byte)
    );

    result_pair_reg u_ch5_pair (
        .clk       (MCLK),
        .rst       (RESET),
        .load      (ch5_load),
        .result    (CONV_RESULT),
        .high_byte (ch5_result_high_byte),
        .low_byte  (ch5_result_low_byte)
    );

    result_pair_reg u_ch6_pair (
        .clk       (MCLK),
        .rst       (RESET),
        .load      (ch6_load),
        .result    (CONV_RESULT),
        .high_byte (ch6_result_high_byte),
        .low_byte  (ch6_result_low_byte)
    );

    result_pair_reg u_ch7_pair (
        .clk       (MCLK),
        .rst       (RESET),
        .load      (ch7_load),
        .result    (CONV_RESULT),
        .high_byte (ch7_result_high_byte),
        .low_byte  (ch7_result_low_byte)
    );

    output_trigger u_out0_trigger (
        .clk        (MCLK),
        .rst        (RESET),
        .mask_we    (out0_mask_we),
        .mask_wdata (WDATA),
        .alert      (ALERT),
        .mask       (output0_alert_trigger_mask),
        .trigger    (trigger0)
    );

    output_trigger u_out1_trigger (
        .clk        (MCLK),
        .rst        (RESET),
        .mask_we    (out1_mask_we),
        .mask_wdata (WDATA),
        .alert      (ALERT),
        .mask       (output1_alert_trigger_mask),
        .trigger    (trigger1)
    );

    output_trigger u_out2_trigger (
        .clk        (MCLK),
        .rst        (RESET),
        .mask_we    (out2_mask_we),
        .mask_wdata (WDATA),
        .alert      (ALERT),
        .mask       (output2_alert_trigger_mask),
        .trigger    (trigger2)
    );

    assign sel_ch3_high  = (ADDR == `ADDR_CH3_HIGH);
    assign sel_ch4_low   = (ADDR == `ADDR_CH4_LOW); // RULE4
    assign sel_ch4_high  = (ADDR == `ADDR_CH4_HIGH); // RULE4
    assign sel_ch5_low   = (ADDR == `ADDR_CH5_LOW); // RULE4
    assign sel_ch5_high  = (ADDR == `ADDR_CH5_HIGH); // RULE4
    assign sel_ch6_low   = (ADDR == `ADDR_CH6_LOW); // RULE4
    assign sel_ch6_high  = (ADDR == `ADDR_CH6_HIGH); // RULE4
    assign sel_ch7_low   = (ADDR == `ADDR_CH7_LOW); // RULE4
    assign sel_ch7_high  = (ADDR == `ADDR_CH7_HIGH); // RULE4
    assign sel_out0_mask = (ADDR == `ADDR_OUT0_MASK); // RULE9
    assign sel_out1_mask = (ADDR == `ADDR_OUT1_MASK); // RULE9
    assign sel_out2_mask = (ADDR == `ADDR_OUT2_MASK); // RULE9

    assign sel_mapped = sel_ch3_high
                      | sel_ch4_low
                      | sel_ch4_high
                      | sel_ch5_low
                      | sel_ch5_high
                      | sel_ch6_low
                      | sel_ch6_high
                      | sel_ch7_low
                      | sel_ch7_high
                      | sel_out0_mask
                      | sel_out1_mask
                      | sel_out2_mask;

    // Result addresses get no write enable, so a write there is simply dropped.
    assign out0_mask_we = WR & sel_out0_mask; // RULE9
    assign out1_mask_we = WR & sel_out1_mask; // RULE9
    assign out2_mask_we = WR & sel_out2_mask; // RULE9

    assign read_ch3_high  = {8{sel_ch3_high}} & ch3_result_high_byte;
    assign read_ch4_low   = {8{sel_ch4_low}} & ch4_result_low_byte;
    assign read_ch4_high  = {8{sel_ch4_high}} & ch4_result_high_byte;
    assign read_ch5_low   = {8{sel_ch5_low}} & ch5_result_low_byte;
    assign read_ch5_high  = {8{sel_ch5_high}} & ch5_result_high_byte;
    assign read_ch6_low   = {8{sel_ch6_low}} & ch6_result_low_byte;
    assign read_ch6_high  = {8{sel_ch6_high}} & ch6_result_high_byte;
    assign read_ch7_low   = {8{sel_ch7_low}} & ch7_result_low_byte;
    assign read_ch7_high  = {8{sel_ch7_high}} & ch7_result_high_byte;
    assign read_out0_mask = {8{sel_out0_mask}} & output0_alert_trigger_mask;
    assign read_out1_mask = {8{sel_out1_mask}} & output1_alert_trigger_mask;
    assign read_out2_mask = {8{sel_out2_mask}} & output2_alert_trigger_mask;

    // The selects are exclusive, so the OR of the gated bytes is the read mux.
    assign read_mux = read_ch3_high
                    | read_ch4_low
                    | read_ch4_high
                    | read_ch5_low
                    | read_ch5_high
                    | read_ch6_low
                    | read_ch6_high
                    | read_ch7_low
                    | read_ch7_high
                    | read_out0_mask
                    | read_out1_mask
                    | read_out2_mask;

    always @* begin
        rdata_d = `READ_IDLE;
        if (RD) begin
            if (sel_mapped) begin
                rdata_d = read_mux;
            end else begin
                rdata_d = `UNMAPPED_READ;
            end
        end
    end

    // Read data stand for the one cycle after the strobe and are zero otherwise.
    always @(posedge MCLK) begin
        if (RESET) begin
            RDATA <= `READ_IDLE;
        end else begin
            RDATA <= rdata_d;
        end
    end

    // A trigger loads the output's programmed value; without one the output holds.
    always @* begin
        digital_output_d = DIGITAL_OUTPUT;
        if (trigger0 == `OUT_UPDATE_LEVEL) begin
            digital_output_d[0] = OUT_VALUE[0]; // RULE6 RULE7
        end
        if (trigger1 == `OUT_UPDATE_LEVEL) begin
            digital_output_d[1] = OUT_VALUE[1]; // RULE6 RULE7
        end
        if (trigger2 == `OUT_UPDATE_LEVEL) begin
            digital_output_d[2] = OUT_VALUE[2]; // RULE6 RULE7
        end
    end

    always @(posedge MCLK) begin
        if (RESET) begin
            DIGITAL_OUTPUT <= `OUTPUT_RESET;
        end else begin
            DIGITAL_OUTPUT <= digital_output_d;
        end
    end
endmodule

//--- rtl/result_trigger_consts.vh
`ifndef RESULT_TRIGGER_CONSTS_VH
`define RESULT_TRIGGER_CONSTS_VH

`define ADDR_CH3_HIGH       8'hA7
`define ADDR_CH4_LOW        8'hA8
`define ADDR_CH4_HIGH       8'hA9
`define ADDR_CH5_LOW        8'hAA
`define ADDR_CH5_HIGH       8'hAB
`define ADDR_CH6_LOW        8'hAC
`define ADDR_CH6_HIGH       8'hAD
`define ADDR_CH7_LOW        8'hAE
`define ADDR_CH7_HIGH       8'hAF
`define ADDR_OUT0_MASK      8'hC3
`define ADDR_OUT1_MASK      8'hC5
`define ADDR_OUT2_MASK      8'hC7
`define RESULT_RESET        16'h0000
`define MASK_RESET          8'h02
`define UNMAPPED_READ       8'h00
`define RESULT_HIGH_MSB     15
`define RESULT_HIGH_LSB     8
`define RESULT_LOW_MSB      7
`define RESULT_LOW_LSB      0
`define OUT_UPDATE_LEVEL    1'b1
`define READ_IDLE           8'h00
`define OUTPUT_RESET        3'h0

`endif

//--- rtl/result_pair_reg.v
`timescale 1ns/1ps
`include "result_trigger_consts.vh"

// Holds both bytes of one channel's latest result, loaded in the same edge.
module result_pair_reg (
    input  wire        clk,
    input  wire        rst,
    input  wire        load,
    input  wire [15:0] result,
    output wire [7:0]  high_byte,
    output wire [7:0]  low_byte
);
    reg [15:0] value_q;

    always @(posedge clk) begin
        if (rst) begin
            value_q <= `RESULT_RESET; // RULE3
        end else if (load) begin
            value_q <= result; // RULE10
        end
    end

    assign high_byte = value_q[`RESULT_HIGH_MSB:`RESULT_HIGH_LSB]; // RULE1
    assign low_byte  = value_q[`RESULT_LOW_MSB:`RESULT_LOW_LSB]; // RULE2
endmodule

//--- rtl/output_trigger.v
`timescale 1ns/1ps
`include "result_trigger_consts.vh"

// One digital output: a trigger mask register and the gated event update.
module output_trigger (
    input  wire       clk,
    input  wire       rst,
    input  wire       mask_we,
    input  wire [7:0] mask_wdata,
    input  wire [7:0] alert,
    output wire [7:0] mask,
    output wire       trigger
);
    reg [7:0] mask_q;

    always @(posedge clk) begin
        if (rst) begin
            mask_q <= `MASK_RESET; // RULE8
        end else if (mask_we) begin
            mask_q <= mask_wdata; // RULE8
        end
    end

    assign mask = mask_q;
    // Bit n of the mask selects channel n, whatever the channel's mode.
    assign trigger = |(alert & mask_q); // RULE5 RULE6 RULE7
endmodule

//--- bench/result_trigger_sva.sv
`timescale 1ns/1ps
module result_trigger_sva (
    input wire logic        MCLK,
    input wire logic        RESET,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic [7:0]  RDATA,
    input wire logic [7:0]  CONV_DONE,
    input wire logic [7:0]  ALERT,
    input wire logic [15:0] CONV_RESULT,
    input wire logic [2:0]  OUT_VALUE,
    input wire logic [2:0]  DIGITAL_OUTPUT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    a_high_byte: assert property (CONV_DONE[4] ##1 (RD && ADDR == 8'hA9 && !CONV_DONE[4])
        |=> RDATA == $past(CONV_RESULT[15:8], 2)) else $error("high byte");
    a_low_byte: assert property (CONV_DONE[7] ##1 (RD && ADDR == 8'hAE && !CONV_DONE[7])
        |=> RDATA == $past(CONV_RESULT[7:0], 2)) else $error("low byte");
    a_result_zero: assert property ($fell(RESET) && RD && ADDR == 8'hAC
        |=> RDATA == 8'h00) else $error("result reset");
    a_unmapped_zero: assert property (RD && ADDR == 8'hB0 |=> RDATA == 8'h00)
        else $error("unmapped");
    a_mask_reset: assert property ($fell(RESET) ##1 (RD && ADDR == 8'hC3)
        |=> RDATA == 8'h02) else $error("mask reset");
    a_mask_rw: assert property ((WR && ADDR == 8'hC5) ##1 (RD && ADDR == 8'hC5)
        |=> RDATA == $past(WDATA, 2)) else $error("mask rw");
    a_alert_fires: assert property ((WR && ADDR == 8'hC3 && WDATA == 8'h80)
        ##1 (!WR && ALERT == 8'h80) |=> DIGITAL_OUTPUT[0] == $past(OUT_VALUE[0]))
        else $error("no update");
    a_masked_quiet: assert property ($fell(RESET) ##0 (ALERT == 8'hFD) [*3]
        |-> DIGITAL_OUTPUT == 3'h0) else $error("masked alert");
endmodule
bind result_trigger_regs result_trigger_sva i_sva (
    .MCLK           (MCLK),
    .RESET          (RESET),
    .WR             (WR),
    .RD             (RD),
    .ADDR           (ADDR),
    .WDATA          (WDATA),
    .RDATA          (RDATA),
    .CONV_DONE      (CONV_DONE),
    .ALERT          (ALERT),
    .CONV_RESULT    (CONV_RESULT),
    .OUT_VALUE      (OUT_VALUE),
    .DIGITAL_OUTPUT (DIGITAL_OUTPUT)
);

//--- bench/host_model.sv
`timescale 1ns/1ps
// Host on the register port; a call drives one cycle, and its strobes hold until the next call.
module host_model (
    input wire logic       MCLK,
    output logic [7:0]     ADDR,
    output logic [7:0]     WDATA,
    output logic           WR,
    output logic           RD
);
    initial {ADDR, WDATA, WR, RD} = 18'h0;
    task automatic op(input logic w, r, input logic [7:0] a, d);
        WR <= w;
        RD <= r;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
    endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    logic MCLK = 0, RESET = 1;
    logic [7:0] CONV_DONE = 0, ALERT = 0, RDATA, er, m [3];
    logic [15:0] CONV_RESULT = 0, res [8];
    logic [2:0] OUT_VALUE = 0, DIGITAL_OUTPUT, eo;
    logic [31:0] rv, rs;
    wire [7:0] ADDR, WDATA;
    wire WR, RD;
    integer failures = 0, n_tests = 0, cycles = 0, seed = 32'hf38049e0, i, k;
    always #5 MCLK = ~MCLK;
    host_model i_host (
        .MCLK  (MCLK),
        .ADDR  (ADDR),
        .WDATA (WDATA),
        .WR    (WR),
        .RD    (RD)
    );
    result_trigger_regs i_dut (
        .MCLK           (MCLK),
        .RESET          (RESET),
        .ADDR           (ADDR),
        .WDATA          (WDATA),
        .WR             (WR),
        .RD             (RD),
        .RDATA          (RDATA),
        .CONV_DONE      (CONV_DONE),
        .CONV_RESULT    (CONV_RESULT),
        .ALERT          (ALERT),
        .OUT_VALUE      (OUT_VALUE),
        .DIGITAL_OUTPUT (DIGITAL_OUTPUT)
    );
    task close_out;
        $display("failures %0d tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Alerts see the mask from before a write on the same edge; stimulus avoids that overlap.
    always @(posedge MCLK) begin
        cycles = cycles + 1;
        if (cycles > 1000) begin
            failures++;
            close_out;
        end
        er = 0;
        if (RESET) begin
            eo = 0;
            for (k = 0; k < 8; k++) res[k] = 0;
            for (k = 0; k < 3; k++) m[k] = 8'h02;
        end else begin
            if (RD && ADDR >= 8'hA7 && ADDR <= 8'hAF)
                er = ADDR[0] ? res[ADDR[3:1]][15:8] : res[ADDR[3:1]][7:0];
            if (RD && ADDR[7:4] == 4'hC && ADDR[0] && ADDR[3:1] inside {1, 2, 3})
                er = m[ADDR[3:1] - 1];
            for (k = 0; k < 3; k++) if (|(ALERT & m[k])) eo[k] = OUT_VALUE[k];
            if (WR && ADDR[7:4] == 4'hC && ADDR[0] && ADDR[3:1] inside {1, 2, 3})
                m[ADDR[3:1] - 1] = WDATA;
            for (k = 3; k < 8; k++) if (CONV_DONE[k]) res[k] = CONV_RESULT;
        end
    end
    always @(negedge MCLK) if (!RESET) begin
        n_tests += 2;
        if (RDATA !== er || DIGITAL_OUTPUT !== eo) begin
            failures++;
            $display("unexpected at %0t: rd %h/%h out %b/%b", $time, RDATA, er, DIGITAL_OUTPUT, eo);
        end
    end
    task step(input logic w, r, input logic [7:0] a, d, cd, al);
        rs = $random(seed);
        CONV_DONE <= cd;
        ALERT <= al;
        CONV_RESULT <= rs[15:0];
        OUT_VALUE <= rs[18:16];
        i_host.op(w, r, a, d);
    endtask
    initial begin
        repeat (12) @(posedge MCLK);
        RESET <= 0;
        step(0, 1, 8'hAC, 0, 0, 8'hFD);
        step(0, 1, 8'hC3, 0, 0, 8'hFD);
        step(0, 1, 8'hB0, 0, 0, 8'hFD);
        step(1, 0, 8'hC5, 8'h81, 0, 0);
        step(0, 1, 8'hC5, 0, 0, 0);
        step(1, 0, 8'hC3, 8'h80, 0, 0);
        step(0, 0, 0, 0, 0, 8'h80);
        step(1, 0, 8'hA9, 8'hFF, 8'h10, 0);
        step(0, 1, 8'hA9, 0, 8'h80, 0);
        step(0, 1, 8'hAE, 0, 0, 0);
        for (i = 0; i < 400; i++) begin
            rv = $random(seed);
            step(rv[0], !rv[0] && rv[1], 8'hA6 + rv[7:2] % 35, rv[15:8],
                 rv[1] ? 8'h00 : rv[23:16], rv[0] ? 8'h00 : rv[31:24]);
        end
        step(0, 0, 0, 0, 0, 0);
        // A second reset after random traffic must bring results and masks back.
        RESET <= 1;
        repeat (3) @(posedge MCLK);
        RESET <= 0;
        step(0, 1, 8'hAC, 0, 0, 8'hFD);
        step(0, 1, 8'hC3, 0, 0, 8'hFD);
        step(0, 1, 8'hC5, 0, 0, 8'hFD);
        step(0, 0, 0, 0, 0, 0);
        close_out;
    end
endmodule
